/* src/isp_programming_sequence.sv */
// In-system configuration sequencer behind a four-wire test port.
// Assumes test port pins arrive asynchronously; the system clock is
// much faster than the test clock, which is found by edge sampling.
// Notes on behaviour
// - Instructions, addresses, data enter on test input
// - Read-back data leaves serially on test output
// - Entering mode moves pins glitch-free, 1 ms
// - Erase instruction gives one 100 ms pulse
// - Each address programmed with one pulse
// - Verify reads each address, shifts data out
// - Leaving mode returns pins glitch-free, 1 ms
// - Port logic follows the standard configuration scheme
`timescale 1ns/10ps
module isp_programming_sequence
  import ips_pkg::*;
#(
  parameter int AW = 4,
  parameter int DW = 8,
  parameter logic [DR_W-1:0] ID_CODE = 32'h0a5a_5001, // arbitrary value
  parameter int unsigned MODE_CYCLES = MODE_CYC,
  parameter int unsigned ERASE_CYCLES = ERASE_CYC,
  parameter int unsigned PROG_CYCLES = PROG_CYC
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Test port
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  // Pin control and cell pulses
  output logic o_in_system_config_mode,
  output logic o_pin_freeze,
  output logic o_erase_pulse,
  output logic o_prog_pulse,
  output logic o_read_pulse
);

  localparam int DEPTH = 1 << AW;
  localparam logic [DW-1:0] ERASED = '1;

  typedef struct packed {
    ips_sync_s sy;
    ips_tap_e tap;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_sh;
    logic [DR_W-1:0] dr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    ips_job_e job;
    logic mode;
    logic freeze;
    logic tdo;
    ips_pulse_s pl;
    logic [DEPTH-1:0][DW-1:0] cells;
  } ips_state_s;

  ips_state_s s;
  ips_state_s next_s;
  logic t_start;
  logic [TMR_W-1:0] t_cycles;
  logic t_busy;
  logic t_done;
  logic tck_rise;
  logic tck_fall;

  // Test port controller transitions
  function automatic ips_tap_e ips_tap_next(ips_tap_e st, logic tms);
    case (st)
      TAP_RESET: ips_tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: ips_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: ips_tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: ips_tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: ips_tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: ips_tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: ips_tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: ips_tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: ips_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: ips_tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: ips_tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: ips_tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: ips_tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: ips_tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: ips_tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: ips_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default: ips_tap_next = TAP_RESET;
    endcase
  endfunction : ips_tap_next

  // Test clock edges from the synchronised copy
  assign tck_rise = s.sy.tck[1] && !s.sy.tck[2];
  assign tck_fall = !s.sy.tck[1] && s.sy.tck[2];

  // Shared pulse and transition timer
  ips_pulse_timer u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(t_start),
    .i_cycles(t_cycles),
    .o_busy(t_busy),
    .o_done(t_done)
  );

  // Next-state logic for the whole sequencer
  always_comb
  begin
    next_s = s;
    t_start = 1'b0;
    t_cycles = '0;
    next_s.sy.tck = {s.sy.tck[1:0], i_tck};
    next_s.sy.tms = {s.sy.tms[0], i_tms};
    next_s.sy.tdi = {s.sy.tdi[0], i_tdi};
    if (tck_rise)
    begin
      next_s.tap = ips_tap_next(s.tap, s.sy.tms[1]);
      case (s.tap)
        TAP_RESET: next_s.ir = OP_IDCODE;
        TAP_CAP_IR: next_s.ir_sh = IR_CAPTURE;
        TAP_SHIFT_IR: next_s.ir_sh = {s.sy.tdi[1], s.ir_sh[IR_W-1:1]};
        TAP_CAP_DR:
        begin
          // Identity or read-back word loaded for shifting out
          if (s.ir == OP_IDCODE)
            next_s.dr = ID_CODE;
          else if (s.ir == OP_VERIFY)
            next_s.dr = DR_W'({s.addr, s.rdata});
          else
            next_s.dr = '0;
        end
        TAP_SHIFT_DR:
        begin
          if (s.ir == OP_BYPASS)
            next_s.dr[0] = s.sy.tdi[1];
          else
            next_s.dr = {s.sy.tdi[1], s.dr[DR_W-1:1]};
        end
        TAP_UPD_IR:
        begin
          next_s.ir = s.ir_sh;
          if (!t_busy && s.job == JOB_NONE)
          begin
            if (s.ir_sh == OP_ENABLE && !s.mode)
            begin
              next_s.job = JOB_ENTER;
              next_s.freeze = 1'b1;
              t_start = 1'b1;
              t_cycles = TMR_W'(MODE_CYCLES);
            end
            else if (s.ir_sh == OP_DISABLE && s.mode)
            begin
              next_s.job = JOB_EXIT;
              next_s.freeze = 1'b1;
              t_start = 1'b1;
              t_cycles = TMR_W'(MODE_CYCLES);
            end
            else if (s.ir_sh == OP_ERASE && s.mode)
            begin
              next_s.job = JOB_ERASE;
              next_s.pl.erase = 1'b1;
              t_start = 1'b1;
              t_cycles = TMR_W'(ERASE_CYCLES);
            end
          end
        end
        TAP_UPD_DR:
        begin
          if (!t_busy && s.job == JOB_NONE && s.mode)
          begin
            if (s.ir == OP_PROGRAM)
            begin
              next_s.addr = s.dr[AW+DW-1:DW];
              next_s.wdata = s.dr[DW-1:0];
              next_s.job = JOB_PROG;
              next_s.pl.prog = 1'b1;
              t_start = 1'b1;
              t_cycles = TMR_W'(PROG_CYCLES);
            end
            else if (s.ir == OP_VERIFY)
            begin
              next_s.addr = s.dr[AW+DW-1:DW];
              next_s.job = JOB_READ;
              next_s.pl.read = 1'b1;
              t_start = 1'b1;
              t_cycles = TMR_W'(READ_CYC);
            end
          end
        end
        default: next_s.ir = s.ir;
      endcase
    end
    // Serial output changes on the falling test clock
    if (tck_fall)
    begin
      if (s.tap == TAP_SHIFT_DR)
        next_s.tdo = s.dr[0];
      else if (s.tap == TAP_SHIFT_IR)
        next_s.tdo = s.ir_sh[0];
      else
        next_s.tdo = 1'b0;
    end
    // Completion of the timed job
    if (t_done)
    begin
      case (s.job)
        JOB_ENTER: next_s.mode = 1'b1;
        JOB_EXIT: next_s.mode = 1'b0;
        JOB_ERASE: next_s.cells = {DEPTH{ERASED}};
        JOB_PROG: next_s.cells[s.addr] = s.wdata;
        JOB_READ: next_s.rdata = s.cells[s.addr];
        default: next_s.rdata = s.rdata;
      endcase
      next_s.job = JOB_NONE;
      next_s.freeze = 1'b0;
      next_s.pl = '0;
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s <= '0;
      s.ir <= OP_IDCODE;
      s.cells <= {DEPTH{ERASED}};
    end
    else
      s <= next_s;
  end

  // Outputs straight from flip-flops
  assign o_tdo = s.tdo;
  assign o_in_system_config_mode = s.mode;
  assign o_pin_freeze = s.freeze;
  assign o_erase_pulse = s.pl.erase;
  assign o_prog_pulse = s.pl.prog;
  assign o_read_pulse = s.pl.read;

  shift_in_a : assert property (@(posedge i_clk) disable iff (i_rst)
    tck_rise && s.tap == TAP_SHIFT_DR && s.ir != OP_BYPASS
    |=> s.dr[DR_W-1] == $past(s.sy.tdi[1]))
    else $error("test input bit not shifted in");

  tdo_on_fall_a : assert property (@(posedge i_clk) disable iff (i_rst)
    !tck_fall |=> $stable(o_tdo))
    else $error("test output moved off the falling edge");

  enter_clean_a : assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_in_system_config_mode) |-> $past(o_pin_freeze) && !o_pin_freeze)
    else $error("mode entered without a freeze window");

  exit_clean_a : assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_in_system_config_mode) |-> $past(o_pin_freeze) && !o_pin_freeze)
    else $error("mode left without a freeze window");

  erase_needs_mode_a : assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_erase_pulse) |-> (o_in_system_config_mode && t_busy)[*2])
    else $error("erase pulse outside configuration mode");

  erase_clears_a : assert property (@(posedge i_clk) disable iff (i_rst)
    t_done && s.job == JOB_ERASE |=> s.cells == {DEPTH{ERASED}} && !o_erase_pulse)
    else $error("erase pulse did not clear the cells");

  prog_writes_a : assert property (@(posedge i_clk) disable iff (i_rst)
    t_done && s.job == JOB_PROG |=> s.cells[$past(s.addr)] == $past(s.wdata))
    else $error("program pulse did not write the cell");

  read_loads_a : assert property (@(posedge i_clk) disable iff (i_rst)
    t_done && s.job == JOB_READ |=> s.rdata == $past(s.cells[s.addr]))
    else $error("read pulse did not fetch the cell");

  one_pulse_a : assert property (@(posedge i_clk) disable iff (i_rst)
    $onehot0({o_erase_pulse, o_prog_pulse, o_read_pulse}))
    else $error("more than one cell pulse active");

  ir_capture_a : assert property (@(posedge i_clk) disable iff (i_rst)
    tck_rise && s.tap == TAP_CAP_IR |=> s.ir_sh == IR_CAPTURE)
    else $error("instruction capture value wrong");

endmodule : isp_programming_sequence

/* src/ips_pkg.sv */
// Shared constants and types for the in-system configuration sequencer.
// Assumes a 50 MHz system clock and a four-wire test port from outside.
package ips_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ = 50_000_000;

  // Pulse and mode-transition times in their own units
  localparam int unsigned MODE_TIME_US = 1000;
  localparam int unsigned ERASE_TIME_MS = 100;
  localparam int unsigned PROG_TIME_US = 100;
  localparam int unsigned READ_TIME_US = 1;

  // Derived cycle counts
  localparam int unsigned MODE_CYC = MODE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ERASE_CYC = ERASE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned PROG_CYC = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned READ_CYC = READ_TIME_US * (CLK_HZ / 1_000_000);

  // Register widths
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int TMR_W = 32;

  // Instruction codes
  localparam logic [IR_W-1:0] OP_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] OP_ENABLE = 4'h2;
  localparam logic [IR_W-1:0] OP_DISABLE = 4'h3;
  localparam logic [IR_W-1:0] OP_ERASE = 4'h4;
  localparam logic [IR_W-1:0] OP_PROGRAM = 4'h5;
  localparam logic [IR_W-1:0] OP_VERIFY = 4'h6;
  localparam logic [IR_W-1:0] OP_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // Test port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } ips_tap_e;

  // Timed job in progress
  typedef enum logic [2:0] {
    JOB_NONE, JOB_ENTER, JOB_EXIT, JOB_ERASE, JOB_PROG, JOB_READ
  } ips_job_e;

  // Synchronised test port inputs
  typedef struct packed {
    logic [2:0] tck;
    logic [1:0] tms;
    logic [1:0] tdi;
  } ips_sync_s;

  // Cell pulse outputs
  typedef struct packed {
    logic erase;
    logic prog;
    logic read;
  } ips_pulse_s;

endpackage : ips_pkg

/* src/ips_pulse_timer.sv */
// Down-counter that times one cell pulse or mode transition.
// Assumes the start request is a single-cycle strobe from the same clock.
`timescale 1ns/10ps
module ips_pulse_timer
  import ips_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Request
  input wire logic i_start,
  input wire logic [TMR_W-1:0] i_cycles,
  // Status
  output logic o_busy,
  output logic o_done
);

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic busy;
    logic done;
  } ips_tmr_s;

  ips_tmr_s s;
  ips_tmr_s next_s;

  // Load on start, count down, strobe done at the end
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    if (i_start && !s.busy)
    begin
      next_s.cnt = i_cycles;
      next_s.busy = 1'b1;
    end
    else if (s.busy)
    begin
      if (s.cnt <= TMR_W'(1))
      begin
        next_s.cnt = '0;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
      else
      begin
        next_s.cnt = s.cnt - TMR_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign o_busy = s.busy;
  assign o_done = s.done;

  // Busy lasts until done
  timer_ends_a : assert property (@(posedge i_clk) disable iff (i_rst)
    s.busy && s.cnt == TMR_W'(1) |=> s.done && !s.busy)
    else $error("timer did not finish on last count");

endmodule : ips_pulse_timer

/* tb/ips_prog_model.sv */
// Programmer model driving the four-wire test port.
// Assumes the bench clock paces a 160 ns test clock.
`timescale 1ns/10ps
module ips_prog_model
  import ips_pkg::*;
(
  // Pacing clock
  input wire logic i_clk,
  // Test port
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  // Test clock low, parked in reset
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end

  // One tck period; tdo taken just before the fall
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(posedge i_clk);
    #1 o_tck = 1'b1;
    repeat (4) @(posedge i_clk);
    #1 tdo = i_tdo;
    o_tck = 1'b0;
  endtask : tick

  // Reset the controller and park in idle
  task automatic tap_reset();
    logic t;
    repeat (5) tick(1'b1, o_tdi, t);
    tick(1'b0, ~o_tdi, t);
  endtask : tap_reset

  // One scan from idle to idle; clock stands still after
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
    output logic [31:0] dout);
    logic t;
    dout = '0;
    tick(1'b1, ~o_tdi, t);
    if (ir)
      tick(1'b1, ~o_tdi, t);
    tick(1'b0, ~o_tdi, t);
    tick(1'b0, ~o_tdi, t);
    // Bits go out LSB first, tms high on the last
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], t);
      dout[i] = t;
    end
    tick(1'b1, ~o_tdi, t);
    tick(1'b0, ~o_tdi, t);
    o_tdi = ~o_tdi;
  endtask : scan
endmodule : ips_prog_model

/* tb/testbench.sv */
// Self-checking bench for the in-system configuration sequencer.
// Assumes shortened pulse counts and a read pulse of READ_CYC.
`timescale 1ns/10ps
module testbench
  import ips_pkg::*;
();
  localparam int MC = 20;
  localparam int EC = 40;
  localparam int PC = 10;
  localparam logic [31:0] ID_VAL = 32'h1234_5679; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, tdo, mode, frz, ers, prg, rdp;
  logic [31:0] d;
  logic id_ok;
  logic [3:0] adr [4] = '{4'h0, 4'hf, 4'h7, 4'h0};
  logic [7:0] dat [4] = '{8'h3c, 8'hc5, 8'hff, 8'h3c};
  int hi;
  int failures = 0;
  int check_count = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  // Programmer and device
  ips_prog_model model_u (.i_clk(clk), .o_tck(tck), .o_tms(tms),
    .o_tdi(tdi), .i_tdo(tdo));
  isp_programming_sequence #(.ID_CODE(ID_VAL), .MODE_CYCLES(MC),
    .ERASE_CYCLES(EC), .PROG_CYCLES(PC)) dut_u (.i_clk(clk), .i_rst(rst),
    .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo),
    .o_in_system_config_mode(mode), .o_pin_freeze(frz),
    .o_erase_pulse(ers), .o_prog_pulse(prg), .o_read_pulse(rdp));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      failures++;
    end
  endtask : check

  // Verdict
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Select a watched output
  function automatic logic pulse(input int sel);
    case (sel)
      0: return frz;
      1: return ers;
      2: return prg;
      default: return rdp;
    endcase
  endfunction : pulse

  // Width at the figure or up to two cycles above it
  function automatic logic near(input int n, input int w);
    return n >= w && n <= w + 2;
  endfunction : near

  // Scan while counting high cycles of one output
  task automatic run(input logic ir, input logic [31:0] din, input int n,
    input int sel, output logic [31:0] dout, output int h);
    h = 0;
    fork
      model_u.scan(ir, din, n, dout);
      repeat (600)
      begin
        @(posedge clk);
        #1 if (pulse(sel) === 1'b1) h++;
      end
    join
  endtask : run

  // Idle outputs, default identity, erase refused outside mode
  task automatic t_reset();
    check({mode, frz, ers, prg, rdp}, 0);
    model_u.tap_reset();
    run(1'b0, 0, 32, 3, d, hi);
    check(d, ID_VAL);
    run(1'b1, OP_ERASE, 4, 1, d, hi);
    check(d[3:0], IR_CAPTURE);
    check(hi, 0);
    run(1'b1, OP_BYPASS, 4, 3, d, hi);
    run(1'b0, 32'h0000_0006, 4, 3, d, hi);
    check(d[3:0], 4'hc);
  endtask : t_reset

  // Enter mode; a second request is ignored
  task automatic t_enter();
    run(1'b1, OP_ENABLE, 4, 0, d, hi);
    check(near(hi, MC), 1);
    check(mode, 1);
    run(1'b1, OP_ENABLE, 4, 0, d, hi);
    check(hi, 0);
  endtask : t_enter

  // Identity read inside mode
  task automatic t_id();
    run(1'b1, OP_IDCODE, 4, 3, d, hi);
    run(1'b0, 0, 32, 3, d, hi);
    id_ok = d === ID_VAL;
    check(d, ID_VAL);
  endtask : t_id

  // Single erase pulse
  task automatic t_erase();
    run(1'b1, OP_ERASE, 4, 1, d, hi);
    check(near(hi, EC), 1);
  endtask : t_erase

  // Two addresses back to back, junk in the upper bits
  task automatic t_prog();
    run(1'b1, OP_PROGRAM, 4, 2, d, hi);
    for (int i = 0; i < 2; i++)
    begin
      run(1'b0, {20'hfffff, adr[i], dat[i]}, 32, 2, d, hi);
      check(near(hi, PC), 1);
    end
  endtask : t_prog

  // Each scan returns the previous address read
  task automatic t_verify();
    run(1'b1, OP_VERIFY, 4, 3, d, hi);
    for (int i = 0; i < 4; i++)
    begin
      run(1'b0, {20'h0, adr[i], 8'h0}, 32, 3, d, hi);
      check(near(hi, READ_CYC), 1);
      if (i > 0)
        check(d, {20'h0, adr[i - 1], dat[i - 1]});
    end
    run(1'b0, 0, 32, 3, d, hi);
    check(d, {20'h0, adr[3], dat[3]});
  endtask : t_verify

  // Leave mode; programming afterwards is ignored
  task automatic t_exit();
    run(1'b1, OP_DISABLE, 4, 0, d, hi);
    check(near(hi, MC), 1);
    check(mode, 0);
    run(1'b1, OP_PROGRAM, 4, 2, d, hi);
    run(1'b0, 32'h0000_0f00, 32, 2, d, hi);
    check(hi, 0);
  endtask : t_exit

  // Full pattern flow, then a verification-only pass
  initial
  begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1 t_reset();
    t_enter();
    t_id();
    if (id_ok)
    begin
      t_erase();
      t_prog();
      t_verify();
    end
    t_exit();
    t_enter();
    t_id();
    if (id_ok)
      t_verify();
    t_exit();
    stop_test();
  end
endmodule : testbench
